// ==== design/clp_pkg.sv ====
// constants for the controller power-mode and interrupt block
package clp_pkg;
  localparam int CLK_MHZ = 125;
  // recovery delay after power-down entered without sleep, in ns
  localparam int RECOVERY_NS = 200;
  localparam int RECOVERY_CYC = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
  // wake-up low-pass filter minimum pulse, in ns
  localparam int WAKE_FILT_NS = 2000;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int RESYNC_BITS = 11;
  localparam int BUSOFF_RUNS = 128;
  localparam int NUM_TXBUF = 3;
  // error-state encodings for the tx and rx state fields
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_PASSIVE = 2'h2;
  localparam logic [1:0] ST_BUSOFF = 2'h3;
  typedef enum logic [5:0] {
    CLP_DISABLED = 6'h01,
    CLP_NORMAL = 6'h02,
    CLP_DRAIN = 6'h04,
    CLP_SLEEP = 6'h08,
    CLP_PDOWN = 6'h10,
    CLP_RECOVER = 6'h20
  } clp_mode_t;
endpackage : clp_pkg

// ==== design/clp_core.sv ====
// power-mode sequencing, wake-up and interrupt flags of the can controller
`timescale 1ns/1ps
module clp_core (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic module_enable_bit_in,
  input wire logic stop_in_wait_bit_in,
  input wire logic cpu_wait_in,
  input wire logic cpu_stop_in,
  input wire logic cpu_int_mask_in,
  input wire logic sleep_request_bit_in,
  input wire logic wakeup_enable_bit_in,
  input wire logic wakeup_filter_bit_in,
  input wire logic can_receive_pin_in,
  input wire logic proto_tx_in,
  input wire logic proto_tx_active_in,
  input wire logic proto_rx_active_in,
  input wire logic bus_idle_in,
  input wire logic recessive_bit_in,
  input wire logic [2:0] tx_scheduled_in,
  input wire logic [2:0] tx_abort_done_in,
  input wire logic rx_eof_in,
  input wire logic rx_queue_pending_in,
  input wire logic rx_overrun_in,
  input wire logic [1:0] tx_err_state_in,
  input wire logic [1:0] rx_err_state_in,
  input wire logic [2:0] tx_empty_clr_in,
  input wire logic rx_full_clr_in,
  input wire logic wakeup_clr_in,
  input wire logic status_clr_in,
  input wire logic overrun_clr_in,
  input wire logic wakeup_int_enable_in,
  input wire logic status_change_int_enable_in,
  input wire logic overrun_int_enable_in,
  input wire logic rx_full_int_enable_in,
  input wire logic [2:0] tx_empty_int_enables_in,
  output logic sleep_ack_bit_out,
  output logic sleep_req_view_out,
  output logic core_clk_en_out,
  output logic reg_access_ok_out,
  output logic proto_run_out,
  output logic rx_shift_allow_out,
  output logic abort_allow_out,
  output logic busoff_count_en_out,
  output logic can_rx_internal_out,
  output logic can_transmit_pin_out,
  output logic [2:0] tx_buffer_empty_flag_out,
  output logic rx_full_flag_out,
  output logic wakeup_int_flag_out,
  output logic status_change_flag_out,
  output logic overrun_flag_out,
  output logic [1:0] tx_state_field_out,
  output logic [1:0] rx_state_field_out,
  output logic irq_wakeup_out,
  output logic irq_error_out,
  output logic irq_rx_out,
  output logic irq_tx_out,
  output logic [5:0] mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic rx_s1, rx_s2;
  logic slp_s1, slp_s2;
  logic ack_s1, ack_s2;
  logic sleep_core;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_s1 <= 1'h1;
      rx_s2 <= 1'h1;
    end else begin
      rx_s1 <= can_receive_pin_in;
      rx_s2 <= rx_s1;
    end
  end

  // request into the core side and ack back to the register side
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slp_s1 <= 1'h0;
      slp_s2 <= 1'h0;
      ack_s1 <= 1'h0;
      ack_s2 <= 1'h0;
    end else begin
      slp_s1 <= sleep_request_bit_in;
      slp_s2 <= slp_s1;
      ack_s1 <= sleep_core;
      ack_s2 <= ack_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake-up detection
  logic rx_masked;
  logic [7:0] filt_cnt;
  logic bus_activity;
  clp_pkg::clp_mode_t mode;
  clp_pkg::clp_mode_t next_mode;

  assign rx_masked = wakeup_enable_bit_in ? rx_s2 : 1'h1;

  // filter needs a dominant level that persists; raw mode takes any dominant sample
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filt_cnt <= 8'h00;
    end else if (rx_masked) begin
      filt_cnt <= 8'h00;
    end else if (filt_cnt != 8'(clp_pkg::WAKE_FILT_CYC)) begin
      filt_cnt <= filt_cnt + 8'h01;
    end
  end

  assign bus_activity = wakeup_filter_bit_in ?
      (filt_cnt == 8'(clp_pkg::WAKE_FILT_CYC)) : !rx_masked;

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer
  logic pdown_req;
  logic slept_before_pd;
  logic [7:0] rec_cnt;
  logic [3:0] resync_cnt;
  logic resync_done;
  logic tx_pending;
  logic stale_req;

  assign pdown_req = cpu_stop_in || (cpu_wait_in && stop_in_wait_bit_in);
  assign tx_pending = |tx_scheduled_in;
  assign sleep_core = (mode == clp_pkg::CLP_SLEEP);

  always_comb begin
    next_mode = mode;
    case (mode)
      clp_pkg::CLP_DISABLED: begin
        if (module_enable_bit_in) next_mode = clp_pkg::CLP_NORMAL;
      end
      clp_pkg::CLP_NORMAL: begin
        if (pdown_req) next_mode = clp_pkg::CLP_PDOWN;
        else if (slp_s2 && !stale_req) next_mode = clp_pkg::CLP_DRAIN;
      end
      clp_pkg::CLP_DRAIN: begin
        if (pdown_req) next_mode = clp_pkg::CLP_PDOWN;
        else if (!slp_s2) next_mode = clp_pkg::CLP_NORMAL;
        else if (!tx_pending && !proto_rx_active_in && !proto_tx_active_in
                 && (bus_idle_in || !proto_rx_active_in))
          next_mode = clp_pkg::CLP_SLEEP;
      end
      clp_pkg::CLP_SLEEP: begin
        if (pdown_req) next_mode = clp_pkg::CLP_PDOWN;
        else if (bus_activity || !slp_s2) next_mode = clp_pkg::CLP_NORMAL;
      end
      clp_pkg::CLP_PDOWN: begin
        if (!pdown_req) begin
          if (slept_before_pd) next_mode = clp_pkg::CLP_NORMAL;
          else next_mode = clp_pkg::CLP_RECOVER;
        end
      end
      clp_pkg::CLP_RECOVER: begin
        if (pdown_req) next_mode = clp_pkg::CLP_PDOWN;
        else if (rec_cnt == 8'(clp_pkg::RECOVERY_CYC)) next_mode = clp_pkg::CLP_NORMAL;
      end
      default: next_mode = clp_pkg::CLP_DISABLED;
    endcase
    if (!module_enable_bit_in) next_mode = clp_pkg::CLP_DISABLED;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) mode <= clp_pkg::CLP_DISABLED;
    else mode <= next_mode;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slept_before_pd <= 1'h0;
    end else if (mode != clp_pkg::CLP_PDOWN && next_mode == clp_pkg::CLP_PDOWN) begin
      slept_before_pd <= sleep_core;
    end
  end

  // a bus wake leaves the request standing; it must drop before it counts again,
  // otherwise the block would fall straight back into sleep
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stale_req <= 1'h0;
    end else if (!slp_s2) begin
      stale_req <= 1'h0;
    end else if (sleep_core && next_mode == clp_pkg::CLP_NORMAL) begin
      stale_req <= 1'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rec_cnt <= 8'h00;
    else if (mode == clp_pkg::CLP_RECOVER) rec_cnt <= rec_cnt + 8'h01;
    else rec_cnt <= 8'h00;
  end

  // counts recessive bit strobes after waking; a waking frame is skipped
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      resync_cnt <= 4'h0;
    end else if (mode != clp_pkg::CLP_NORMAL) begin
      resync_cnt <= 4'h0;
    end else if (!resync_done && recessive_bit_in) begin
      resync_cnt <= resync_cnt + 4'h1;
    end else if (!resync_done && !rx_s2) begin
      resync_cnt <= 4'h0;
    end
  end
  assign resync_done = (resync_cnt == 4'(clp_pkg::RESYNC_BITS));

  ////////////////////////////////////////////////////////////////////////////
  // mode-derived controls
  logic running;
  assign running = (mode == clp_pkg::CLP_NORMAL) || (mode == clp_pkg::CLP_DRAIN);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      can_transmit_pin_out <= 1'h1;
      core_clk_en_out <= 1'h0;
      proto_run_out <= 1'h0;
    end else begin
      can_transmit_pin_out <= (running && resync_done && next_mode != clp_pkg::CLP_PDOWN) ?
          proto_tx_in : 1'h1;
      core_clk_en_out <= running || (next_mode == clp_pkg::CLP_RECOVER);
      proto_run_out <= running && resync_done;
    end
  end

  assign sleep_ack_bit_out = ack_s2 && sleep_request_bit_in;
  assign sleep_req_view_out = sleep_request_bit_in;
  assign reg_access_ok_out = (mode != clp_pkg::CLP_PDOWN);
  assign rx_shift_allow_out = running && resync_done;
  assign abort_allow_out = running;
  assign busoff_count_en_out = running;
  assign can_rx_internal_out = rx_masked;
  assign mode_out = mode;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: a set in the cycle of a clear wins
  logic [2:0] tx_empty;
  logic [2:0] next_tx_empty;
  logic rx_full, wake_flag, stat_flag, ovr_flag;
  logic [1:0] tx_st, rx_st;
  logic wake_set, stat_set;
  logic sleep_armed;

  always_comb begin
    next_tx_empty = tx_empty;
    for (int i = 0; i < clp_pkg::NUM_TXBUF; i++) begin
      if (!tx_scheduled_in[i] || tx_abort_done_in[i]) next_tx_empty[i] = 1'h1;
      else if (tx_empty_clr_in[i]) next_tx_empty[i] = 1'h0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) tx_empty <= 3'h7;
    else tx_empty <= next_tx_empty;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rx_full <= 1'h0;
    else if (rx_eof_in && rx_shift_allow_out) rx_full <= 1'h1;
    else if (rx_full_clr_in) rx_full <= rx_queue_pending_in && rx_shift_allow_out;
  end

  // wake interrupt needs acknowledged sleep, possibly followed by power-down
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) sleep_armed <= 1'h0;
    else if (running) sleep_armed <= 1'h0;
    else if (sleep_core) sleep_armed <= 1'h1;
  end
  assign wake_set = sleep_armed && wakeup_enable_bit_in && wakeup_int_enable_in &&
      bus_activity && (sleep_core || mode == clp_pkg::CLP_PDOWN);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) wake_flag <= 1'h0;
    else if (wake_set) wake_flag <= 1'h1;
    else if (wakeup_clr_in) wake_flag <= 1'h0;
  end

  assign stat_set = ((tx_err_state_in != tx_st) && (tx_err_state_in != clp_pkg::ST_OK)) ||
      ((rx_err_state_in != rx_st) && (rx_err_state_in != clp_pkg::ST_OK));

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_st <= clp_pkg::ST_OK;
      rx_st <= clp_pkg::ST_OK;
      stat_flag <= 1'h0;
    end else begin
      tx_st <= tx_err_state_in;
      rx_st <= rx_err_state_in;
      if (stat_set) stat_flag <= 1'h1;
      else if (status_clr_in) stat_flag <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) ovr_flag <= 1'h0;
    else if (rx_overrun_in) ovr_flag <= 1'h1;
    else if (overrun_clr_in) ovr_flag <= 1'h0;
  end

  assign tx_buffer_empty_flag_out = tx_empty;
  assign rx_full_flag_out = rx_full;
  assign wakeup_int_flag_out = wake_flag;
  assign status_change_flag_out = stat_flag;
  assign overrun_flag_out = ovr_flag;
  assign tx_state_field_out = tx_st;
  assign rx_state_field_out = rx_st;

  // pending while any flag stands with its enable set; the cpu mask gates all four lines
  assign irq_wakeup_out = !cpu_int_mask_in && wake_flag && wakeup_int_enable_in;
  assign irq_error_out = !cpu_int_mask_in && ((stat_flag && status_change_int_enable_in) ||
      (ovr_flag && overrun_int_enable_in));
  assign irq_rx_out = !cpu_int_mask_in && rx_full && rx_full_int_enable_in;
  assign irq_tx_out = !cpu_int_mask_in && |(tx_empty & tx_empty_int_enables_in);

endmodule : clp_core

// ==== dv/clp_bus_model.sv ====
// can wire stand-in: wired dominant level and recessive bit ticks
`timescale 1ns/1ps
module clp_bus_model (
  input wire logic ref_clk_in,
  input wire logic tx_pin_in,
  input wire logic dom_in,
  output logic rx_pin_out,
  output logic rec_tick_out
);
  logic [1:0] div = 2'h0;
  // either node pulls the wire dominant
  assign rx_pin_out = tx_pin_in & ~dom_in;
  // one tick per four-cycle bit, so resync takes about 44 cycles
  always_ff @(posedge ref_clk_in) begin
    div <= div + 2'h1;
    rec_tick_out <= rx_pin_out && div == 2'h3;
  end
endmodule : clp_bus_model

// ==== dv/clp_core_chk.sv ====
// port checks for the power-mode and interrupt block
`timescale 1ns/1ps
module clp_core_chk (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic module_enable_bit_in,
  input wire logic cpu_wait_in,
  input wire logic cpu_stop_in,
  input wire logic cpu_int_mask_in,
  input wire logic sleep_request_bit_in,
  input wire logic wakeup_enable_bit_in,
  input wire logic proto_tx_active_in,
  input wire logic proto_rx_active_in,
  input wire logic bus_idle_in,
  input wire logic [2:0] tx_scheduled_in,
  input wire logic rx_eof_in,
  input wire logic rx_full_int_enable_in,
  input wire logic sleep_ack_bit_out,
  input wire logic core_clk_en_out,
  input wire logic reg_access_ok_out,
  input wire logic rx_shift_allow_out,
  input wire logic abort_allow_out,
  input wire logic busoff_count_en_out,
  input wire logic can_rx_internal_out,
  input wire logic can_transmit_pin_out,
  input wire logic [2:0] tx_buffer_empty_flag_out,
  input wire logic rx_full_flag_out,
  input wire logic irq_rx_out,
  input wire logic irq_tx_out,
  input wire logic [5:0] mode_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_idle_req;
    $rose(sleep_request_bit_in) && mode_out == 6'h02 && tx_scheduled_in == 3'h0
      && !proto_tx_active_in && !proto_rx_active_in && bus_idle_in;
  endsequence
  // the ack must cross two synchronisers, so never in the first two cycles
  sequence s_ack_late;
    !sleep_ack_bit_out ##1 !sleep_ack_bit_out ##[1:8] sleep_ack_bit_out;
  endsequence
  chk_sleep_handshake: assert property (s_idle_req |-> s_ack_late)
    else $error("sleep ack timing wrong");
  chk_ack_shown: assert property ((mode_out == 6'h08 && sleep_request_bit_in)[*4]
    |-> sleep_ack_bit_out) else $error("sleep without ack");
  chk_stop_pdown: assert property (cpu_stop_in && module_enable_bit_in
    |-> ##[1:2] mode_out == 6'h10) else $error("stop did not power down");
  chk_pdown_tx: assert property (mode_out == 6'h10 |-> can_transmit_pin_out)
    else $error("tx pin dominant in power-down");
  chk_pdown_regs: assert property ((mode_out == 6'h10)[*2]
    |-> !reg_access_ok_out && !core_clk_en_out) else $error("power-down access");
  chk_sleep_clks: assert property ((mode_out == 6'h08)[*2]
    |-> !core_clk_en_out && reg_access_ok_out) else $error("sleep clocks wrong");
  chk_sleep_hold: assert property (mode_out == 6'h08
    |-> !rx_shift_allow_out && !abort_allow_out && !busoff_count_en_out)
    else $error("activity during sleep");
  chk_wake_mask: assert property (!wakeup_enable_bit_in |-> can_rx_internal_out)
    else $error("rx not held recessive");
  chk_irq_mask: assert property (cpu_int_mask_in |-> !irq_rx_out && !irq_tx_out)
    else $error("irq through global mask");
  chk_irq_rx: assert property (rx_full_flag_out && rx_full_int_enable_in
    && !cpu_int_mask_in |-> irq_rx_out) else $error("rx irq missing");
  chk_tx_empty: assert property (1'b1 |=> (tx_buffer_empty_flag_out
    & ~$past(tx_scheduled_in)) == ~$past(tx_scheduled_in)) else $error("tx empty flag");
  chk_rx_full: assert property (rx_eof_in && rx_shift_allow_out |=> rx_full_flag_out)
    else $error("rx full not set");
  chk_enable_normal: assert property ($rose(module_enable_bit_in) && mode_out == 6'h01
    && !cpu_stop_in && !cpu_wait_in |=> mode_out == 6'h02) else $error("enable ignored");
endmodule : clp_core_chk
bind clp_core clp_core_chk u_chk (.*);

// ==== dv/clp_core_test.sv ====
// self-checking bench for the power-mode and interrupt block
`timescale 1ns/1ps
module clp_core_test;
  logic ref_clk_in, rst_b_in, module_enable_bit_in, stop_in_wait_bit_in, cpu_wait_in;
  logic cpu_stop_in, cpu_int_mask_in, sleep_request_bit_in, wakeup_enable_bit_in, dom;
  logic wakeup_filter_bit_in, can_receive_pin_in, proto_tx_in, proto_tx_active_in;
  logic proto_rx_active_in, bus_idle_in, recessive_bit_in, rx_eof_in, rx_queue_pending_in;
  logic rx_overrun_in, rx_full_clr_in, wakeup_clr_in, status_clr_in, overrun_clr_in;
  logic wakeup_int_enable_in, status_change_int_enable_in, overrun_int_enable_in;
  logic rx_full_int_enable_in, sleep_ack_bit_out, sleep_req_view_out, core_clk_en_out;
  logic reg_access_ok_out, proto_run_out, rx_shift_allow_out, abort_allow_out;
  logic busoff_count_en_out, can_rx_internal_out, can_transmit_pin_out, rx_full_flag_out;
  logic wakeup_int_flag_out, status_change_flag_out, overrun_flag_out, irq_wakeup_out;
  logic irq_error_out, irq_rx_out, irq_tx_out;
  logic [2:0] tx_scheduled_in, tx_abort_done_in, tx_empty_clr_in, tx_empty_int_enables_in;
  logic [2:0] tx_buffer_empty_flag_out;
  logic [1:0] tx_err_state_in, rx_err_state_in, tx_state_field_out, rx_state_field_out;
  logic [5:0] mode_out;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  clp_core dut (.*);
  clp_bus_model bus (.ref_clk_in(ref_clk_in), .tx_pin_in(can_transmit_pin_out),
    .dom_in(dom), .rx_pin_out(can_receive_pin_in), .rec_tick_out(recessive_bit_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc
  // copies got at the call, so a call right after an edge sees pre-edge values; then waits 1 ns
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    #1;
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_mode(input logic [5:0] m, input int lim);
    int i;
    for (i = 0; i < lim && mode_out !== m; i++) @(posedge ref_clk_in);
  endtask : wait_mode
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_flags;
    cyc(1); rx_eof_in <= 1'b1; tx_scheduled_in <= 3'h5; tx_empty_clr_in <= 3'h5;
    cyc(1); rx_eof_in <= 1'b0; tx_empty_clr_in <= 3'h0;
    cyc(1); chk("rx_full", 8'h01, rx_full_flag_out);
    chk("txe", 8'h02, tx_buffer_empty_flag_out);
    chk("irq_tx", 8'h01, irq_tx_out);
    cyc(1); cpu_int_mask_in <= 1'b1;
    cyc(1); chk("irq_rx", 8'h00, irq_rx_out);
    cyc(1); cpu_int_mask_in <= 1'b0; rx_eof_in <= 1'b1; rx_full_clr_in <= 1'b1;
    cyc(1); rx_eof_in <= 1'b0; rx_full_clr_in <= 1'b0;
    cyc(1); chk("rx_full", 8'h01, rx_full_flag_out);
    cyc(1); rx_full_clr_in <= 1'b1; rx_queue_pending_in <= 1'b1;
    cyc(1); rx_full_clr_in <= 1'b0; rx_queue_pending_in <= 1'b0;
    cyc(1); chk("rx_full", 8'h01, rx_full_flag_out);
    cyc(1); rx_full_clr_in <= 1'b1; rx_overrun_in <= 1'b1; tx_err_state_in <= clp_pkg::ST_WARN;
    rx_err_state_in <= clp_pkg::ST_PASSIVE;
    cyc(1); rx_full_clr_in <= 1'b0; rx_overrun_in <= 1'b0;
    cyc(1); chk("rx_full", 8'h00, rx_full_flag_out);
    chk("ovr", 8'h01, overrun_flag_out);
    chk("stat", 8'h01, status_change_flag_out);
    chk("tx_state_field", 8'h01, tx_state_field_out);
    chk("irq_err", 8'h01, irq_error_out);
    chk("rx_state_field", 8'h02, rx_state_field_out);
    cyc(1); status_clr_in <= 1'b1; overrun_clr_in <= 1'b1;
    cyc(1); status_clr_in <= 1'b0; overrun_clr_in <= 1'b0;
    cyc(1); chk("stat", 8'h00, status_change_flag_out);
    chk("ovr", 8'h00, overrun_flag_out);
    chk("irq_err", 8'h00, irq_error_out);
  endtask : t_flags
  task automatic t_sleep;
    cyc(1); tx_scheduled_in <= 3'h1;
    cyc(2); sleep_request_bit_in <= 1'b1;
    cyc(12); chk("ack", 8'h00, sleep_ack_bit_out);
    chk("mode", 8'h04, mode_out);
    cyc(1); tx_scheduled_in <= 3'h0;
    wait_mode(6'h08, 20);
    cyc(4); chk("ack", 8'h01, sleep_ack_bit_out);
    chk("req_view", 8'h01, sleep_req_view_out);
    chk("rx_shift", 8'h00, rx_shift_allow_out);
    cyc(1); dom <= 1'b1;
    cyc(10); chk("mode", 8'h08, mode_out);
    cyc(1); dom <= 1'b0; sleep_request_bit_in <= 1'b0;
    wait_mode(6'h02, 20);
    chk("mode", 8'h02, mode_out);
    chk("wake_flag", 8'h00, wakeup_int_flag_out);
  endtask : t_sleep
  task automatic t_wake;
    cyc(1); wakeup_enable_bit_in <= 1'b1; wakeup_filter_bit_in <= 1'b1;
    cyc(60); sleep_request_bit_in <= 1'b1;
    wait_mode(6'h08, 20);
    cyc(1); dom <= 1'b1;
    cyc(20); dom <= 1'b0;
    cyc(30); chk("mode", 8'h08, mode_out);
    cyc(1); wakeup_filter_bit_in <= 1'b0; dom <= 1'b1;
    wait_mode(6'h02, 20);
    dom <= 1'b0; sleep_request_bit_in <= 1'b0;
    chk("wake_flag", 8'h01, wakeup_int_flag_out);
    chk("irq_wake", 8'h01, irq_wakeup_out);
    chk("run", 8'h00, proto_run_out);
    cyc(80); chk("run", 8'h01, proto_run_out);
    cyc(1); wakeup_clr_in <= 1'b1;
    cyc(1); wakeup_clr_in <= 1'b0;
    cyc(1); chk("wake_flag", 8'h00, wakeup_int_flag_out);
    chk("irq_wake", 8'h00, irq_wakeup_out);
  endtask : t_wake
  task automatic t_pdown;
    cyc(1); cpu_wait_in <= 1'b1; rx_eof_in <= 1'b1;
    cyc(1); rx_eof_in <= 1'b0;
    cyc(4); chk("mode", 8'h02, mode_out);
    chk("irq_rx", 8'h01, irq_rx_out);
    cyc(1); stop_in_wait_bit_in <= 1'b1; proto_tx_in <= 1'b0;
    cyc(3); chk("mode", 8'h10, mode_out);
    chk("tx_pin", 8'h01, can_transmit_pin_out);
    cyc(1); cpu_wait_in <= 1'b0; proto_tx_in <= 1'b1;
    cyc(3); chk("mode", 8'h20, mode_out);
    wait_mode(6'h02, 40);
    chk("mode", 8'h02, mode_out);
    cyc(1); cpu_stop_in <= 1'b1; stop_in_wait_bit_in <= 1'b0;
    cyc(3); chk("mode", 8'h10, mode_out);
    cyc(1); cpu_stop_in <= 1'b0;
  endtask : t_pdown
  initial begin
    {rst_b_in, module_enable_bit_in, stop_in_wait_bit_in, cpu_wait_in, cpu_stop_in, dom,
      cpu_int_mask_in, sleep_request_bit_in, wakeup_enable_bit_in, wakeup_filter_bit_in,
      proto_tx_active_in, proto_rx_active_in, rx_eof_in, rx_queue_pending_in, rx_overrun_in,
      rx_full_clr_in, wakeup_clr_in, status_clr_in, overrun_clr_in, tx_scheduled_in,
      tx_abort_done_in, tx_empty_clr_in, tx_err_state_in, rx_err_state_in} = '0;
    {proto_tx_in, bus_idle_in, wakeup_int_enable_in, status_change_int_enable_in} = 4'hF;
    {overrun_int_enable_in, rx_full_int_enable_in, tx_empty_int_enables_in} = 5'h1A;
    cyc(20); rst_b_in <= 1'b1;
    chk("mode", 8'h01, mode_out);
    chk("clk_en", 8'h00, core_clk_en_out);
    chk("reg_ok", 8'h01, reg_access_ok_out);
    cyc(1); module_enable_bit_in <= 1'b1;
    cyc(2); chk("mode", 8'h02, mode_out);
    cyc(50); chk("run", 8'h01, proto_run_out);
    t_flags();
    t_sleep();
    t_wake();
    t_pdown();
    end_sim();
  end
endmodule : clp_core_test
